// ### rtl/fpc_params.svh
// constants for the flyback pulse control block
// included by the package user; holds definitions only
`ifndef FPC_PARAMS_SVH
`define FPC_PARAMS_SVH

`define FPC_CLK_HZ 10000000
`define FPC_CLK_NS 100
`define FPC_FSW_HZ 65000
`define FPC_PERIOD_CYC (`FPC_CLK_HZ / `FPC_FSW_HZ)
`define FPC_SWAP_DEV 6
`define FPC_DUTY_PCT 80
`define FPC_BLANK_NS 300
`define FPC_BLANK_CYC ((`FPC_BLANK_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_OPP_MS 66
`define FPC_OPP_CYC (`FPC_OPP_MS * (`FPC_CLK_HZ / 1000))
`define FPC_RESTART_MS 1
`define FPC_RESTART_CYC (`FPC_RESTART_MS * (`FPC_CLK_HZ / 1000))
`define FPC_AOV_CYCLES 8

`define FPC_OFF_CTRL 4'h0
`define FPC_OFF_STATUS 4'h4
`define FPC_OFF_MASK 4'h8
`define FPC_OFF_LIVE 4'hc

`define FPC_CTRL_RUN 0
`define FPC_CTRL_SWAP 1
`define FPC_CTRL_RST 2'h3

`define FPC_EV_OPP 0
`define FPC_EV_VCC 1
`define FPC_EV_OTP 2
`define FPC_EV_SKIP 3
`define FPC_EV_AOV 4
`define FPC_EV_CDIS 5

`endif

// ### rtl/fpc_pkg.sv
// types for the flyback pulse control block
// no surroundings assumed
package fpc_pkg;

	// comparator results from the analog front end
	typedef struct packed {
		logic cs_peak;   // cs at fixed peak limit
		logic cs_ctl;    // cs at comp level over 2.5
		logic comp_low;  // comp below comp_disable_threshold
		logic comp_opp;  // comp at over_power_guard level
		logic vcc_ov;    // supply_overvoltage_guard
		logic otp_hot;   // die over temperature, with hysteresis
		logic aux_uv;    // aux_undervoltage_skip comparator
		logic aux_ov;    // aux_overvoltage_guard comparator
	} fpc_cmp_t;

	typedef enum logic [1:0] {
		FPC_RUN = 2'h0,
		FPC_HICCUP = 2'h1
	} fpc_mode_t;

	typedef struct packed {
		fpc_cmp_t s1;
		fpc_cmp_t s2;
		logic [7:0] cnt;
		logic [7:0] prd;
		logic [4:0] swp;
		logic swp_dn;
		logic gate;
		logic skip;
		logic ov_seen;
		logic [3:0] ovc;
		logic [19:0] oppc;
		logic [19:0] rstc;
		fpc_mode_t mode;
		logic [5:0] sts;
		logic [5:0] msk;
		logic [1:0] ctl;
		logic ap_wr;
		logic ap_ok;
		logic [3:0] ap_addr;
	} fpc_st_t;

endpackage

// ### rtl/fpc_top.sv
// flyback gate pulse generator with fault protection and ahb-lite regs
// comparator inputs come from the analog front end, reset is uvlo
//
// Implementation choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "fpc_params.svh"
`default_nettype none

module fpc_top #(
	parameter int unsigned OPP_CYC = `FPC_OPP_CYC,
	parameter int unsigned RESTART_CYC = `FPC_RESTART_CYC
) (
	input wire logic hclk, // 10 mhz clock
	input wire logic hresetn, // async reset, low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write when high
	input wire logic [2:0] hsize, // word only
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic hreadyout, // always ready
	output logic hresp, // always okay
	output logic [31:0] hrdata, // read data
	input wire fpc_pkg::fpc_cmp_t cmp_i, // comparator results
	output logic gate_o, // mosfet gate drive
	output logic irq_o // interrupt, level
);
	import fpc_pkg::*;

	localparam logic [7:0] BLANK = 8'(`FPC_BLANK_CYC);
	localparam logic [7:0] PRD_LO = 8'(`FPC_PERIOD_CYC - `FPC_SWAP_DEV);
	localparam logic [4:0] SWP_MAX = 5'(2 * `FPC_SWAP_DEV);
	localparam logic [3:0] AOV_LAST = 4'(`FPC_AOV_CYCLES - 1);
	localparam logic [19:0] OPP_LAST = 20'(OPP_CYC - 1);
	localparam logic [19:0] RST_LAST = 20'(RESTART_CYC - 1);

	fpc_st_t r;
	fpc_st_t n;
	fpc_cmp_t c;
	logic [15:0] dmax16;
	logic [7:0] dmax;
	logic [7:0] cnt1;
	logic last;
	logic kill;
	logic term;
	logic uv_now;
	logic ov_now;
	logic ov_cyc;
	logic trip_opp;
	logic trip_aov;
	logic trip_vcc;
	logic [4:0] swp_n;
	logic [5:0] ev;
	logic [5:0] clr;

	always_comb begin
		n = r;
		c = r.s2;
		clr = 6'h0;
		ev = 6'h0;
		n.s1 = cmp_i;
		n.s2 = r.s1;
		dmax16 = 16'(r.prd) * 16'(`FPC_DUTY_PCT) / 16'(100);
		dmax = dmax16[7:0];
		cnt1 = r.cnt + 8'h1;
		last = (cnt1 == r.prd);
		kill = c.comp_low | c.vcc_ov | c.otp_hot | (r.mode != FPC_RUN)
			| !r.ctl[`FPC_CTRL_RUN];
		term = (r.cnt >= BLANK) & (c.cs_peak | c.cs_ctl);
		uv_now = !r.gate & c.aux_uv & (r.mode == FPC_RUN);
		ov_now = !r.gate & c.aux_ov & (r.mode == FPC_RUN);
		ov_cyc = r.ov_seen | ov_now;
		trip_opp = 1'b0;
		trip_aov = 1'b0;
		trip_vcc = c.vcc_ov & (r.mode == FPC_RUN);
		// frequency swap: triangle walk of the period
		swp_n = r.swp;
		if (!r.ctl[`FPC_CTRL_SWAP]) begin
			swp_n = 5'(`FPC_SWAP_DEV);
		end else if (r.swp_dn) begin
			swp_n = r.swp - 5'h1;
		end else begin
			swp_n = r.swp + 5'h1;
		end
		if (r.mode == FPC_RUN) begin
			if (c.comp_opp) begin
				n.oppc = r.oppc + 20'h1;
				trip_opp = (r.oppc == OPP_LAST);
			end else begin
				n.oppc = 20'h0;
			end
			if (last) begin
				n.cnt = 8'h0;
				n.gate = !kill & !(r.skip | uv_now);
				n.skip = 1'b0;
				ev[`FPC_EV_SKIP] = r.skip | uv_now;
				n.ov_seen = 1'b0;
				n.ovc = ov_cyc ? r.ovc + 4'h1 : 4'h0;
				trip_aov = ov_cyc & (r.ovc == AOV_LAST);
				n.swp = swp_n;
				n.prd = PRD_LO + 8'(swp_n);
				if (swp_n == 5'h0) begin
					n.swp_dn = 1'b0;
				end else if (swp_n == SWP_MAX) begin
					n.swp_dn = 1'b1;
				end
			end else begin
				n.cnt = cnt1;
				n.gate = r.gate & !kill & !term & (cnt1 < dmax);
				n.skip = r.skip | uv_now;
				n.ov_seen = ov_cyc;
			end
			if (trip_opp | trip_aov | trip_vcc) begin
				n.mode = FPC_HICCUP;
				n.gate = 1'b0;
				n.cnt = 8'h0;
				n.rstc = 20'h0;
				n.oppc = 20'h0;
				n.ovc = 4'h0;
				n.skip = 1'b0;
				n.ov_seen = 1'b0;
			end
		end else begin
			n.gate = 1'b0;
			n.rstc = r.rstc + 20'h1;
			if (r.rstc == RST_LAST) begin
				n.mode = FPC_RUN;
				n.cnt = 8'h0;
			end
		end
		ev[`FPC_EV_OPP] = trip_opp;
		ev[`FPC_EV_VCC] = trip_vcc;
		ev[`FPC_EV_OTP] = c.otp_hot;
		ev[`FPC_EV_AOV] = trip_aov;
		ev[`FPC_EV_CDIS] = c.comp_low;
		// bus data phase: write lands at the end of it
		if (r.ap_wr && r.ap_ok) begin
			if (r.ap_addr == `FPC_OFF_CTRL) begin
				n.ctl = hwdata[1:0];
			end else if (r.ap_addr == `FPC_OFF_STATUS) begin
				clr = hwdata[5:0];
			end else if (r.ap_addr == `FPC_OFF_MASK) begin
				n.msk = hwdata[5:0];
			end
		end
		// new event beats a clear in the same cycle
		n.sts = (r.sts & ~clr) | ev;
		// bus address phase
		if (hsel && htrans[1] && hready) begin
			n.ap_wr = hwrite;
			n.ap_ok = (haddr[31:4] == 28'h0) && (haddr[1:0] == 2'h0);
			n.ap_addr = haddr[3:0];
		end else begin
			n.ap_wr = 1'b0;
			n.ap_ok = 1'b0;
			n.ap_addr = 4'h0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= '0;
			r.ctl <= `FPC_CTRL_RST;
			r.prd <= 8'(`FPC_PERIOD_CYC);
			r.swp <= 5'(`FPC_SWAP_DEV);
		end else begin
			r <= n;
		end
	end

	always_comb begin
		hrdata = 32'h0;
		if (!r.ap_ok || r.ap_wr) begin
			hrdata = 32'h0;
		end else if (r.ap_addr == `FPC_OFF_CTRL) begin
			hrdata = {30'h0, r.ctl};
		end else if (r.ap_addr == `FPC_OFF_STATUS) begin
			hrdata = {26'h0, r.sts};
		end else if (r.ap_addr == `FPC_OFF_MASK) begin
			hrdata = {26'h0, r.msk};
		end else if (r.ap_addr == `FPC_OFF_LIVE) begin
			hrdata = {16'h0, r.mode, r.gate, r.skip, r.ovc, r.s2};
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign gate_o = r.gate;
	assign irq_o = |(r.sts & r.msk);

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_dmax;
		r.gate |-> (r.cnt < dmax);
	endproperty
	a_dmax: assert property (p_dmax) else $error("on-time past max duty");

	property p_blank;
		(r.gate && r.cnt < BLANK && !kill && !last && cnt1 < dmax
			&& r.mode == FPC_RUN && !trip_opp) |=> r.gate;
	endproperty
	a_blank: assert property (p_blank) else $error("pulse cut in blanking");

	property p_peak;
		(r.gate && r.cnt >= BLANK && c.cs_peak) |=> !r.gate;
	endproperty
	a_peak: assert property (p_peak) else $error("peak limit ignored");

	property p_cdis;
		c.comp_low |=> !r.gate;
	endproperty
	a_cdis: assert property (p_cdis) else $error("gate on while disabled");

	property p_vcc;
		(c.vcc_ov && r.mode == FPC_RUN) |=> (!r.gate && r.mode == FPC_HICCUP);
	endproperty
	a_vcc: assert property (p_vcc) else $error("overvoltage not tripped");

	property p_otp;
		c.otp_hot[*2] |-> !r.gate;
	endproperty
	a_otp: assert property (p_otp) else $error("gate on while hot");

	property p_skip;
		(r.skip && last) |=> (!r.gate && !r.skip);
	endproperty
	a_skip: assert property (p_skip) else $error("skip not honoured");

	property p_aov;
		(r.mode == FPC_RUN && last && ov_cyc && r.ovc == AOV_LAST)
			|=> (r.mode == FPC_HICCUP && r.sts[`FPC_EV_AOV]);
	endproperty
	a_aov: assert property (p_aov) else $error("aux overvoltage missed");

	property p_opp;
		(r.mode == FPC_RUN && c.comp_opp && r.oppc == OPP_LAST)
			|=> (r.mode == FPC_HICCUP && !r.gate);
	endproperty
	a_opp: assert property (p_opp) else $error("over power missed");

	property p_recover;
		(r.mode == FPC_HICCUP && r.rstc == RST_LAST) |=> r.mode == FPC_RUN;
	endproperty
	a_recover: assert property (p_recover) else $error("no auto restart");

	property p_start;
		$rose(r.gate) |-> (r.cnt == 8'h0 && !$past(kill) && !$past(r.skip));
	endproperty
	a_start: assert property (p_start) else $error("pulse started badly");

	// every decision sees the comparators two edges late
	property p_sync;
		r.s2 == $past(cmp_i, 2);
	endproperty
	a_sync: assert property (p_sync) else $error("sync depth wrong");

	property p_ctl;
		(r.gate && r.cnt >= BLANK && c.cs_ctl) |=> !r.gate;
	endproperty
	a_ctl: assert property (p_ctl) else $error("comp level ignored");

	property p_range;
		r.prd >= PRD_LO && r.prd <= PRD_LO + 8'(SWP_MAX);
	endproperty
	a_range: assert property (p_range) else $error("period out of range");

	property p_hic_off;
		r.mode == FPC_HICCUP |-> !r.gate;
	endproperty
	a_hic_off: assert property (p_hic_off) else $error("gate on in hiccup");

	property p_ov_on;
		(r.gate && !r.ov_seen && !last) |=> !r.ov_seen;
	endproperty
	a_ov_on: assert property (p_ov_on) else $error("ov seen while on");

	property p_uv_on;
		(r.gate && !r.skip && !last) |=> !r.skip;
	endproperty
	a_uv_on: assert property (p_uv_on) else $error("uv seen while on");

	// a break in the over-power level restarts the delay
	property p_opp_clr;
		(r.mode == FPC_RUN && !c.comp_opp) |=> r.oppc == 20'h0;
	endproperty
	a_opp_clr: assert property (p_opp_clr) else $error("opp count kept");

	property p_run_off;
		!r.ctl[`FPC_CTRL_RUN] |=> !r.gate;
	endproperty
	a_run_off: assert property (p_run_off) else $error("gate on stopped");

	property p_wait;
		(r.mode == FPC_HICCUP && r.rstc != RST_LAST) |=> r.mode == FPC_HICCUP;
	endproperty
	a_wait: assert property (p_wait) else $error("restart too soon");

	property p_skip_clr;
		(r.mode == FPC_RUN && last) |=> !r.skip;
	endproperty
	a_skip_clr: assert property (p_skip_clr) else $error("skip kept");

	property p_ovc_clr;
		(r.mode == FPC_RUN && last && !ov_cyc) |=> r.ovc == 4'h0;
	endproperty
	a_ovc_clr: assert property (p_ovc_clr) else $error("ov count kept");

	property p_vcc_off;
		c.vcc_ov |=> !r.gate;
	endproperty
	a_vcc_off: assert property (p_vcc_off) else $error("gate on in ov");

	property p_otp_sts;
		c.otp_hot |=> r.sts[`FPC_EV_OTP];
	endproperty
	a_otp_sts: assert property (p_otp_sts) else $error("hot not flagged");

	property p_cdis_sts;
		c.comp_low |=> r.sts[`FPC_EV_CDIS];
	endproperty
	a_cdis_sts: assert property (p_cdis_sts) else $error("cdis unflagged");

	// each wrap moves the period one step while swapping
	property p_swap;
		(r.mode == FPC_RUN && last && r.ctl[`FPC_CTRL_SWAP])
			|=> r.prd != $past(r.prd);
	endproperty
	a_swap: assert property (p_swap) else $error("period not swapped");

	property p_fixed;
		(r.mode == FPC_RUN && last && !r.ctl[`FPC_CTRL_SWAP])
			|=> r.prd == 8'(`FPC_PERIOD_CYC);
	endproperty
	a_fixed: assert property (p_fixed) else $error("nominal period wrong");

endmodule

`default_nettype wire

// ### bench/fpc_fet_model.sv
// current sense of the power switch seen by the pulse block
// gate comes from the block, trip delay from the bench
`timescale 1ns/1ps
`default_nettype none
module fpc_fet_model (
	input wire logic hclk, // block clock
	input wire logic gate, // gate drive
	input wire logic [7:0] dly, // on cycles until trip
	output logic cs // sense comparator trip
);
	logic [7:0] n_r;
	// current ramps only while the switch is on
	always_ff @(posedge hclk)
		n_r <= gate ? n_r + 8'h1 : 8'h0;
	assign cs = gate && n_r >= dly;
endmodule
`default_nettype wire

// ### bench/flyback_pwm_protection_control_tb_top.sv
// self-checking bench for the flyback pulse block
// fet model closes the current loop, faults come from the bench
`timescale 1ns/1ps
`default_nettype none
`include "fpc_params.svh"
module flyback_pwm_protection_control_tb_top;
	import fpc_pkg::*;
	localparam int P = `FPC_PERIOD_CYC;
	localparam int DV = `FPC_SWAP_DEV;
	logic hclk = '0, hresetn = '0, hsel = '0, hwrite = '0;
	logic hro, hrsp, gate, irq, cs, pk = '1;
	logic [1:0] htrans = '0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, rd, seed = 32'hf985;
	logic [7:0] dly = 8'hff;
	logic [5:0] flt = '0;
	fpc_cmp_t cmp;
	int failures = 0, tests_run = 0, on, off, k, n, p0, ph;
	int fi[3] = '{5, 3, 2};
	int sb[3] = '{5, 1, 2};
	assign cmp = {cs & pk, cs & ~pk, flt};
	always #50 hclk = ~hclk;
	fpc_top #(.OPP_CYC(50), .RESTART_CYC(20)) dut (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hro),
		.hreadyout(hro), .hresp(hrsp), .hrdata(hrdata), .cmp_i(cmp),
		.gate_o(gate), .irq_o(irq));
	fpc_fet_model fet (.hclk(hclk), .gate(gate), .dly(dly), .cs(cs));
	function logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	function int dmax(input int p);
		return p * `FPC_DUTY_PCT / 100;
	endfunction
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task fin;
		$display("test %0d ended", ph);
		ph++;
	endtask
	task tick(input int c);
		repeat (c) @(posedge hclk);
	endtask
	task tmo;
		k++;
		if (k > 3000) begin
			chk(32'h0, 32'h1);
			give_verdict;
		end
	endtask
	task waitg(input logic v);
		k = 0;
		while (gate !== v) begin
			@(posedge hclk);
			tmo;
		end
	endtask
	task waitr;
		k = 0;
		do begin
			@(posedge hclk);
			tmo;
		end while (hro !== 1'h1);
	endtask
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		waitr;
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		waitr;
		rd = hrdata;
	endtask
	task meas(input logic fresh);
		if (fresh)
			waitg(1'h0);
		waitg(1'h1);
		on = 0;
		off = 0;
		k = 0;
		while (gate === 1'h1) begin
			@(posedge hclk);
			on++;
			tmo;
		end
		while (gate === 1'h0) begin
			@(posedge hclk);
			off++;
			tmo;
		end
	endtask
	task hi(input int c);
		n = 0;
		repeat (c) begin
			@(posedge hclk);
			n += gate !== 1'h0;
		end
	endtask
	initial begin
		tick(4);
		hresetn <= 1'h1;
		tick(1);
		ahb(1'h0, 32'h0, 32'h0);
		chk(rd, 32'h3);
		chk(hrsp, 1'h0);
		ahb(1'h0, 32'h10, 32'h0);
		chk(rd, 32'h0);
		p0 = 0;
		n = 0;
		repeat (3) begin
			meas(1'h0);
			chk(on + off >= P - DV && on + off <= P + DV, 1);
			n += p0 != 0 && on + off != p0;
			p0 = on + off;
		end
		chk(n > 0, 1);
		ahb(1'h1, 32'h0, 32'h1);
		meas(1'h1);
		meas(1'h0);
		chk(on + off, P);
		chk(on <= dmax(P) && on > dmax(P) - 2, 1);
		fin;
		for (int i = 0; i < 7; i++) begin
			seed = xs(seed);
			pk <= i[0];
			dly <= i == 6 ? 8'h0 : 8'h8 + seed[5:0];
			meas(1'h1);
			if (i < 6)
				chk(on >= dly + 2 && on <= dly + 4, 1);
			else
				chk(on > 3 && on < 6, 1);
		end
		dly <= 8'hff;
		fin;
		for (int i = 0; i < 3; i++) begin
			waitg(1'h1);
			flt[fi[i]] <= 1'h1;
			tick(4);
			chk(gate, 0);
			hi(400);
			chk(n, 0);
			flt[fi[i]] <= 1'h0;
			waitg(1'h1);
			ahb(1'h0, 32'h4, 32'h0);
			chk(rd[sb[i]], 1);
			chk(irq, 0);
			ahb(1'h1, 32'h8, 32'h1 << sb[i]);
			tick(1);
			chk(irq, 1);
			ahb(1'h1, 32'h4, 32'h3f);
			tick(1);
			chk(irq, 0);
			ahb(1'h1, 32'h8, 32'h0);
		end
		fin;
		flt[4] <= 1'h1;
		tick(40);
		flt[4] <= 1'h0;
		ahb(1'h0, 32'h4, 32'h0);
		chk(rd[0], 0);
		flt[4] <= 1'h1;
		tick(60);
		hi(10);
		chk(n, 0);
		flt[4] <= 1'h0;
		waitg(1'h1);
		ahb(1'h0, 32'h4, 32'h0);
		chk(rd[0], 1);
		fin;
		waitg(1'h1);
		tick(20);
		flt[1] <= 1'h1;
		tick(1);
		flt[1] <= 1'h0;
		waitg(1'h0);
		waitg(1'h1);
		chk(k < 60, 1);
		waitg(1'h0);
		flt[1] <= 1'h1;
		tick(1);
		flt[1] <= 1'h0;
		waitg(1'h1);
		chk(k > P && k < P + 40, 1);
		meas(1'h1);
		chk(on + off, P);
		fin;
		waitg(1'h0);
		flt[0] <= 1'h1;
		n = 0;
		do begin
			meas(1'h0);
			n++;
		end while (off < P && n < 20);
		flt[0] <= 1'h0;
		chk(n > 5 && n < 10, 1);
		ahb(1'h0, 32'h4, 32'h0);
		chk(rd[4], 1);
		fin;
		give_verdict;
	end
endmodule
`default_nettype wire
